// ### core/erm_pkg.sv
package erm_pkg;

  // page identities and lengths
  localparam logic        PG_VENDOR      = 1'b0;
  localparam logic        PG_RECOV       = 1'b1;
  localparam logic [7:0]  VEND_HDR_RST   = 8'h80;
  localparam logic [7:0]  VEND_LEN       = 8'h0e;
  localparam logic [7:0]  RECOV_HDR_RST  = 8'h81;
  localparam logic [7:0]  RECOV_LEN      = 8'h0a;
  localparam int          VEND_BYTES     = 16;
  localparam int          RECOV_BYTES    = 12;

  // byte offsets, both pages
  localparam logic [3:0]  OFF_HDR        = 4'h0;
  localparam logic [3:0]  OFF_LEN        = 4'h1;
  localparam logic [3:0]  OFF_CTRL       = 4'h2;
  localparam logic [3:0]  OFF_RD_RETRY   = 4'h3;
  localparam logic [3:0]  OFF_WR_RETRY   = 4'h8;
  localparam logic [3:0]  OFF_RTL_HI     = 4'ha;
  localparam logic [3:0]  OFF_RTL_LO     = 4'hb;
  localparam logic [3:0]  OFF_V_AGE_EN   = 4'h5;
  localparam logic [3:0]  OFF_V_OCT_HI   = 4'h6;
  localparam logic [3:0]  OFF_V_OCT_LO   = 4'h7;
  localparam logic [3:0]  OFF_V_TEMP     = 4'h9;
  localparam logic [3:0]  OFF_V_AGE_HI   = 4'ha;
  localparam logic [3:0]  OFF_V_AGE_LO   = 4'hb;
  localparam logic [3:0]  OFF_V_RD_THR   = 4'hc;
  localparam logic [3:0]  OFF_V_WR_THR   = 4'hd;
  localparam logic [3:0]  OFF_V_FMT      = 4'he;
  localparam logic [3:0]  OFF_V_CERT     = 4'hf;

  // field positions
  localparam int BIT_AUTO_WRITE_REALLOC = 7;
  localparam int BIT_AUTO_READ_REALLOC = 6;
  localparam int BIT_TB   = 5;
  localparam int BIT_RC   = 4;
  localparam int BIT_PER  = 2;
  localparam int BIT_DTE  = 1;
  localparam int BIT_SKIP = 7;
  localparam int BIT_AVRM = 6;
  localparam int BIT_AGEN = 1;
  localparam int BIT_SKIP_RESTORE_ON_REASSIGN = 7;
  localparam int BIT_FAST_FORMAT_EN = 5;
  localparam int BIT_FCRT = 5;
  localparam int BIT_RCRT = 3;

  // timing, and the default temperature limit
  localparam int          CLK_HZ         = 20000000;
  localparam int          TICK_MS        = 50;
  localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] RTL_STEP_MS    = 16'h0032;
  localparam logic [7:0]  TEMP_DEFAULT   = 8'h55;

  // writable bits of each byte; the rest keeps its reset image
  function automatic logic [7:0] wmask(input logic pg, input logic [3:0] idx);
    logic [7:0] m;
    m = 8'h00;
    if (pg == PG_RECOV)
    begin
      case (idx)
        4'h2: m = 8'hf6;
        4'h3, 4'h8, 4'ha, 4'hb: m = 8'hff;
        default: m = 8'h00;
      endcase
    end
    else
    begin
      case (idx)
        4'h2: m = 8'h08;
        4'h3: m = 8'h42;
        4'h5: m = 8'h1e;
        4'h6: m = 8'hcf;
        4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd: m = 8'hff;
        4'he: m = 8'ha0;
        4'hf: m = 8'h28;
        default: m = 8'h00;
      endcase
    end
    return m;
  endfunction

  // reset image of each byte
  function automatic logic [7:0] rstv(input logic pg, input logic [3:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (pg == PG_RECOV)
    begin
      case (idx)
        4'h0: v = RECOV_HDR_RST;
        4'h1: v = RECOV_LEN;
        4'h2: v = 8'hc0;
        4'h3, 4'h8: v = 8'h01;
        default: v = 8'h00;
      endcase
    end
    else
    begin
      case (idx)
        4'h0: v = VEND_HDR_RST;
        4'h1: v = VEND_LEN;
        4'h5: v = 8'h0a;
        4'hb: v = 8'h30;
        4'hc: v = 8'h16;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

endpackage

// ### core/erm_sync3.sv
`timescale 1ns/100ps
`default_nettype none

module erm_sync3 #(
  parameter int W = 8
) (
  // clocking
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // async in, clean out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;

  // three stages; the value is taken once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end
    else if (ce)
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        out_r <= s3_r;
    end
  end

  assign dout = out_r;

endmodule
`default_nettype wire

// ### core/erm_timer.sv
`timescale 1ns/100ps
`default_nettype none

module erm_timer (
  // clocking
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // control
  input  wire logic        restart,
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic [15:0] step,
  input  wire logic [15:0] limit,
  // status
  output logic             expired
);

  logic [16:0] elapsed_r;
  logic [16:0] elapsed_nxt;
  logic [17:0] sum;

  // saturating elapsed count, advanced by step on each tick while running
  assign sum         = {1'b0, elapsed_r} + {2'b00, step};
  assign elapsed_nxt = restart ? 17'h00000 :
                       (run && tick) ? (sum[17] ? 17'h1ffff : sum[16:0]) : elapsed_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      elapsed_r <= 17'h00000;
    else if (ce)
      elapsed_r <= elapsed_nxt;
  end

  // zero limit disables; expiry means strictly over the limit
  assign expired = (limit != 16'h0000) && (elapsed_r > {1'b0, limit});

endmodule
`default_nettype wire

// ### core/erm_core.sv
// Operation
// (RQ1) skip reassigned lbas only when skip and continuous set
// (RQ2) av retry mode caps passes, else default count
// (RQ3) time commands, abort overdue with check condition
// (RQ4) command timer counts 50 ms units, zero disables
// (RQ5) temperature warning threshold, zero selects 85
// (RQ6) aging bounds queue wait in 50 ms units
// (RQ7) report read recovery above read threshold
// (RQ8) report write recovery above write threshold
// (RQ9) reassign restores unless skipped, failure zero fills
// (RQ10) fast format writes no customer data blocks
// (RQ11) format certifies only when format certify set
// (RQ12) repurpose certifies only when its bit set
// (RQ13) write defects reallocated only when enabled
// (RQ14) read defects reallocated only when enabled
// (RQ15) transfer unrecovered block only when bit set
// (RQ16) read continuous overrides other recovery bits, reads
// (RQ17) continuous reads drop data checks, keep servo
// (RQ18) post error bit reports recovered errors
// (RQ19) stop on recovered error halts transfer
// (RQ20) initiator sets post error with stop bit
// (RQ21) read retry zero disables recovery, nonzero all
// (RQ22) page length mismatch rejects mode select
// (RQ23) aged commands switch to first come order
// (RQ24) recovery limit in ms, 50 ms grain
// (RQ25) write retry zero disables write recovery
// (RQ26) reserved and obsolete bytes read zero
`timescale 1ns/100ps
`default_nettype none

module erm_core #(
  parameter int         TICK_CYC    = erm_pkg::TICK_CYCLES,
  parameter logic [7:0] DEF_RETRIES = 8'h10
) (
  // clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // mode select byte writes
  input  wire logic       sel_start,
  input  wire logic       sel_wr,
  input  wire logic       sel_page,
  input  wire logic [3:0] sel_idx,
  input  wire logic [7:0] sel_data,
  output logic            sel_reject,
  // mode sense byte reads
  input  wire logic       sense_rd,
  input  wire logic       sense_page,
  input  wire logic [3:0] sense_idx,
  output logic      [7:0] sense_data,
  output logic            sense_valid,
  // command life cycle
  input  wire logic       cmd_start,
  input  wire logic       cmd_is_read,
  input  wire logic       cmd_done,
  output logic            cmd_abort,
  output logic            cmd_active,
  // queue aging
  input  wire logic       queue_wait,
  input  wire logic       queue_restart,
  output logic            fcfs_mode,
  // per lba recovery timing
  input  wire logic       recov_run,
  input  wire logic       recov_restart,
  output logic            recov_timeout,
  // recovery policy to the read and write channel
  output logic            skip_reassigned_lba,
  output logic            read_recovery_en,
  output logic      [7:0] read_pass_cap,
  output logic            write_recovery_en,
  output logic      [7:0] write_pass_cap,
  output logic            data_field_check_en,
  output logic            servo_field_check_en,
  // error events from the channel
  input  wire logic       rec_err,
  input  wire logic       rec_err_write,
  input  wire logic [7:0] rec_step,
  input  wire logic       hard_err,
  output logic            report_recovered,
  output logic            halt_transfer,
  output logic            send_bad_block,
  output logic            check_cond,
  // defects, reassignment, format
  input  wire logic       defect_found,
  input  wire logic       defect_on_write,
  output logic            realloc_req,
  input  wire logic       reassign_start,
  input  wire logic       restore_fail,
  output logic            restore_attempt,
  output logic            zero_fill,
  input  wire logic       format_start,
  input  wire logic       repurpose_done,
  output logic            fast_format_en,
  output logic            certify_req,
  // thermal
  input  wire logic [7:0] temp_c,
  output logic            temp_warn
);

  localparam int PGB = erm_pkg::VEND_BYTES;

  // ---------------------------------------------------------------
  // page byte storage: index [pg*16 + idx]
  logic [7:0] page_r [2*PGB];
  logic       rej_r;
  logic       wr_ok;
  logic       len_bad;
  logic [7:0] exp_len;

  assign exp_len = (sel_page == erm_pkg::PG_RECOV) ? erm_pkg::RECOV_LEN : erm_pkg::VEND_LEN;
  assign len_bad = sel_wr && (sel_idx == erm_pkg::OFF_LEN) && (sel_data != exp_len);
  assign wr_ok   = sel_wr && !rej_r && !len_bad;

  // page bytes; read-only and reserved bits keep their reset image
  genvar g;
  generate
    for (g = 0; g < 2*PGB; g++)
    begin : g_byte
      localparam logic       GP = (g >= PGB);
      localparam logic [3:0] GI = 4'(g % PGB);
      localparam logic [7:0] GM = erm_pkg::wmask(GP, GI);
      localparam logic [7:0] GR = erm_pkg::rstv(GP, GI);
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          page_r[g] <= GR;
        else if (ce && wr_ok && sel_page == GP && sel_idx == GI)
          page_r[g] <= (sel_data & GM) | (GR & ~GM); // RQ26
      end
    end
  endgenerate

  // a wrong length refuses the rest of the select until the next start
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rej_r <= 1'b0;
    else if (ce)
    begin
      if (len_bad)
        rej_r <= 1'b1; // RQ22
      else if (sel_start)
        rej_r <= 1'b0;
    end
  end
  assign sel_reject = rej_r;

  // sense read, registered; beyond the page length reads zero
  logic [7:0] sense_r;
  logic       sense_v_r;
  logic       sense_in;
  assign sense_in = (sense_page == erm_pkg::PG_RECOV) ?
                    (sense_idx < 4'(erm_pkg::RECOV_BYTES)) : 1'b1;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sense_r   <= 8'h00;
      sense_v_r <= 1'b0;
    end
    else if (ce)
    begin
      sense_v_r <= sense_rd;
      if (sense_rd)
        sense_r <= sense_in ? page_r[{sense_page, sense_idx}] : 8'h00; // RQ26
    end
  end
  assign sense_data  = sense_r;
  assign sense_valid = sense_v_r;

  // ---------------------------------------------------------------
  // field extraction
  function automatic logic [7:0] rb(input logic pg, input logic [3:0] idx);
    rb = 8'h00;
  endfunction

  wire [7:0]  r_ctrl   = page_r[{erm_pkg::PG_RECOV, erm_pkg::OFF_CTRL}];
  wire [7:0]  r_rdrc   = page_r[{erm_pkg::PG_RECOV, erm_pkg::OFF_RD_RETRY}];
  wire [7:0]  r_wrrc   = page_r[{erm_pkg::PG_RECOV, erm_pkg::OFF_WR_RETRY}];
  wire [15:0] r_rtl    = {page_r[{erm_pkg::PG_RECOV, erm_pkg::OFF_RTL_HI}],
                          page_r[{erm_pkg::PG_RECOV, erm_pkg::OFF_RTL_LO}]};
  wire [7:0]  v_oct_hi = page_r[{erm_pkg::PG_VENDOR, erm_pkg::OFF_V_OCT_HI}];
  wire [15:0] v_oct    = {4'h0, v_oct_hi[3:0],
                          page_r[{erm_pkg::PG_VENDOR, erm_pkg::OFF_V_OCT_LO}]};
  wire [15:0] v_age    = {page_r[{erm_pkg::PG_VENDOR, erm_pkg::OFF_V_AGE_HI}],
                          page_r[{erm_pkg::PG_VENDOR, erm_pkg::OFF_V_AGE_LO}]};
  wire [7:0]  v_temp   = page_r[{erm_pkg::PG_VENDOR, erm_pkg::OFF_V_TEMP}];
  wire [7:0]  v_rthr   = page_r[{erm_pkg::PG_VENDOR, erm_pkg::OFF_V_RD_THR}];
  wire [7:0]  v_wthr   = page_r[{erm_pkg::PG_VENDOR, erm_pkg::OFF_V_WR_THR}];
  wire [7:0]  v_age_en = page_r[{erm_pkg::PG_VENDOR, erm_pkg::OFF_V_AGE_EN}];
  wire [7:0]  v_fmt    = page_r[{erm_pkg::PG_VENDOR, erm_pkg::OFF_V_FMT}];
  wire [7:0]  v_cert   = page_r[{erm_pkg::PG_VENDOR, erm_pkg::OFF_V_CERT}];

  wire auto_write_realloc         = r_ctrl[erm_pkg::BIT_AUTO_WRITE_REALLOC];
  wire auto_read_realloc          = r_ctrl[erm_pkg::BIT_AUTO_READ_REALLOC];
  wire transfer_unrecovered_block = r_ctrl[erm_pkg::BIT_TB];
  wire read_continuous            = r_ctrl[erm_pkg::BIT_RC];
  wire post_error                 = r_ctrl[erm_pkg::BIT_PER];
  wire stop_on_recovered_error    = r_ctrl[erm_pkg::BIT_DTE];
  wire skip_bit                   = v_oct_hi[erm_pkg::BIT_SKIP];
  wire av_retry_mode              = v_oct_hi[erm_pkg::BIT_AVRM];
  wire queue_aging_en             = v_age_en[erm_pkg::BIT_AGEN];
  wire skip_restore_on_reassign   = v_fmt[erm_pkg::BIT_SKIP_RESTORE_ON_REASSIGN];
  wire fast_fmt_bit               = v_fmt[erm_pkg::BIT_FAST_FORMAT_EN];
  wire format_certify_en          = v_cert[erm_pkg::BIT_FCRT];
  wire repurpose_certify_en       = v_cert[erm_pkg::BIT_RCRT];

  // ---------------------------------------------------------------
  // command tracking: read kind is latched for the command's life
  logic cmd_act_r;
  logic cmd_rd_r;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_act_r <= 1'b0;
      cmd_rd_r  <= 1'b0;
    end
    else if (ce)
    begin
      if (cmd_start)
      begin
        cmd_act_r <= 1'b1;
        cmd_rd_r  <= cmd_is_read;
      end
      else if (cmd_done || cmd_abort)
        cmd_act_r <= 1'b0;
    end
  end
  assign cmd_active = cmd_act_r;

  // continuous mode only governs reads
  wire rc_active = read_continuous && cmd_act_r && cmd_rd_r; // RQ16

  // ---------------------------------------------------------------
  // 50 ms tick shared by all timers
  logic [31:0] pre_r;
  logic        tick;
  assign tick = (pre_r == 32'(TICK_CYC - 1));
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_r <= 32'h00000000;
    else if (ce)
      pre_r <= tick ? 32'h00000000 : pre_r + 32'h00000001;
  end

  // overall command timer, one step per tick
  logic oct_exp;
  erm_timer u_oct (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .restart (cmd_start),
    .run     (cmd_act_r),
    .tick    (tick),
    .step    (16'h0001),
    .limit   (v_oct),     // RQ4
    .expired (oct_exp)
  );

  // queue aging timer, only while aging is on
  logic age_exp;
  erm_timer u_age (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .restart (queue_restart),
    .run     (queue_wait && queue_aging_en),
    .tick    (tick),
    .step    (16'h0001),
    .limit   (v_age),     // RQ6
    .expired (age_exp)
  );

  // per lba recovery timer: ms limit, advanced 50 ms per tick
  logic rtl_exp;
  erm_timer u_rtl (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .restart (recov_restart),
    .run     (recov_run),
    .tick    (tick),
    .step    (erm_pkg::RTL_STEP_MS), // RQ24
    .limit   (r_rtl),
    .expired (rtl_exp)
  );

  // one abort per command when the timer passes its limit
  assign cmd_abort = cmd_act_r && oct_exp && !cmd_done && !cmd_start; // RQ3
  assign fcfs_mode = queue_aging_en && age_exp;                       // RQ23

  // ---------------------------------------------------------------
  // thermal compare on the synchronised sensor value
  logic [7:0] temp_s;
  erm_sync3 #(
    .W (8)
  ) u_temp (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .din     (temp_c),
    .dout    (temp_s)
  );
  wire [7:0] temp_lim = (v_temp == 8'h00) ? erm_pkg::TEMP_DEFAULT : v_temp; // RQ5

  // ---------------------------------------------------------------
  // event decoding; the sticky recovery timeout is read here
  logic rto_r;
  wire [7:0] thr      = rec_err_write ? v_wthr : v_rthr;
  wire       rep_nxt  = rec_err && post_error && !rc_active && (rec_step > thr); // RQ7 RQ8 RQ18
  wire       halt_nxt = rec_err && stop_on_recovered_error && !rc_active;      // RQ19
  wire       bad_nxt  = hard_err && transfer_unrecovered_block && !rc_active;  // RQ15
  wire       chk_nxt  = (hard_err && !rc_active) || cmd_abort
                        || (recov_run && rtl_exp && !rto_r);                    // RQ24
  wire       rel_nxt  = defect_found &&
                        (defect_on_write ? auto_write_realloc : auto_read_realloc); // RQ13 RQ14
  wire       rst_nxt  = reassign_start && !skip_restore_on_reassign;           // RQ9
  wire       zf_nxt   = restore_fail && !skip_restore_on_reassign;             // RQ9
  wire       crt_nxt  = (format_start && format_certify_en)                    // RQ11
                        || (repurpose_done && repurpose_certify_en);           // RQ12

  // policy decoding
  wire       rd_rec_nxt = (r_rdrc != 8'h00) && !rc_active;                     // RQ21
  wire [7:0] rd_cap_nxt = av_retry_mode ? r_rdrc : DEF_RETRIES;               // RQ2
  wire       wr_rec_nxt = (r_wrrc != 8'h00);                                   // RQ25

  // ---------------------------------------------------------------
  // registered event pulses and the sticky recovery timeout
  logic rep_r;
  logic halt_r;
  logic bad_r;
  logic chk_r;
  logic rel_r;
  logic rat_r;
  logic zf_r;
  logic crt_r;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rep_r  <= 1'b0;
      halt_r <= 1'b0;
      bad_r  <= 1'b0;
      chk_r  <= 1'b0;
      rel_r  <= 1'b0;
      rat_r  <= 1'b0;
      zf_r   <= 1'b0;
      crt_r  <= 1'b0;
      rto_r  <= 1'b0;
    end
    else if (ce)
    begin
      rep_r  <= rep_nxt;
      halt_r <= halt_nxt;
      bad_r  <= bad_nxt;
      chk_r  <= chk_nxt;
      rel_r  <= rel_nxt;
      rat_r  <= rst_nxt;
      zf_r   <= zf_nxt;
      crt_r  <= crt_nxt;
      rto_r  <= recov_restart ? 1'b0 : (rto_r || (recov_run && rtl_exp));
    end
  end

  // registered policy levels
  logic       skip_r;
  logic       rd_rec_r;
  logic [7:0] rd_cap_r;
  logic       wr_rec_r;
  logic [7:0] wr_cap_r;
  logic       dchk_r;
  logic       fast_format_en_r;
  logic       twarn_r;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      skip_r   <= 1'b0;
      rd_rec_r <= 1'b0;
      rd_cap_r <= 8'h00;
      wr_rec_r <= 1'b0;
      wr_cap_r <= 8'h00;
      dchk_r   <= 1'b1;
      fast_format_en_r   <= 1'b0;
      twarn_r  <= 1'b0;
    end
    else if (ce)
    begin
      skip_r   <= skip_bit && read_continuous;  // RQ1
      rd_rec_r <= rd_rec_nxt;
      rd_cap_r <= rd_cap_nxt;
      wr_rec_r <= wr_rec_nxt;
      wr_cap_r <= r_wrrc;                       // RQ25
      dchk_r   <= !rc_active;                   // RQ17
      fast_format_en_r   <= fast_fmt_bit;                 // RQ10
      twarn_r  <= (temp_s >= temp_lim);         // RQ5
    end
  end

  // outputs
  assign report_recovered     = rep_r;
  assign halt_transfer        = halt_r;
  assign send_bad_block       = bad_r;
  assign check_cond           = chk_r;
  assign realloc_req          = rel_r;
  assign restore_attempt      = rat_r;
  assign zero_fill            = zf_r;
  assign certify_req          = crt_r;
  assign recov_timeout        = rto_r;
  assign skip_reassigned_lba  = skip_r;
  assign read_recovery_en     = rd_rec_r;
  assign read_pass_cap        = rd_cap_r;
  assign write_recovery_en    = wr_rec_r;
  assign write_pass_cap       = wr_cap_r;
  assign data_field_check_en  = dchk_r;
  assign servo_field_check_en = 1'b1;       // RQ17
  assign fast_format_en       = fast_format_en_r;
  assign temp_warn            = twarn_r;

endmodule
`default_nettype wire

// ### sim/erm_chk.sv
`timescale 1ns/100ps
`default_nettype none
module erm_chk (
  // clock, reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // causes
  input wire logic rec_err,
  input wire logic hard_err,
  input wire logic defect_found,
  input wire logic restore_fail,
  input wire logic sel_start,
  // effects
  input wire logic cmd_abort,
  input wire logic cmd_active,
  input wire logic check_cond,
  input wire logic report_recovered,
  input wire logic halt_transfer,
  input wire logic send_bad_block,
  input wire logic realloc_req,
  input wire logic zero_fill,
  input wire logic sel_reject,
  input wire logic servo_field_check_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // report, halt, bad block, realloc and zero fill trace back to their cause one cycle earlier
  property p_abort; cmd_abort |-> cmd_active ##1 check_cond; endproperty
  a_abort: assert property (p_abort) else $error("abort out of place");
  property p_rep; report_recovered |-> $past(rec_err); endproperty
  a_rep: assert property (p_rep) else $error("report without error");
  property p_halt; halt_transfer |-> $past(rec_err); endproperty
  a_halt: assert property (p_halt) else $error("halt without error");
  property p_bad; send_bad_block |-> $past(hard_err); endproperty
  a_bad: assert property (p_bad) else $error("bad block without hard error");
  property p_realloc; realloc_req |-> $past(defect_found); endproperty
  a_realloc: assert property (p_realloc) else $error("realloc without defect");
  property p_zero; zero_fill |-> $past(restore_fail); endproperty
  a_zero: assert property (p_zero) else $error("zero fill without failure");
  property p_rej; sel_reject && !sel_start |=> sel_reject; endproperty
  a_rej: assert property (p_rej) else $error("reject dropped early");
  property p_servo; servo_field_check_en; endproperty
  a_servo: assert property (p_servo) else $error("servo check off");
  c_abort: cover property (cmd_abort);
  c_rep: cover property (report_recovered);
  c_rej: cover property (sel_reject);
endmodule
bind erm_core erm_chk i_erm_chk (.*);
`default_nettype wire

// ### sim/erm_init.sv
`timescale 1ns/100ps
`default_nettype none
module erm_init (
  // clock
  input  wire logic       ref_clk,
  // mode select
  output logic            sel_start,
  output logic            sel_wr,
  output logic            sel_page,
  output logic      [3:0] sel_idx,
  output logic      [7:0] sel_data,
  // mode sense
  output logic            sense_rd,
  output logic            sense_page,
  output logic      [3:0] sense_idx,
  input  wire logic [7:0] sense_data,
  input  wire logic       sense_valid
);
  // idle request lines
  initial
  begin
    {sel_start, sel_wr, sel_page, sel_idx, sel_data} = '0;
    {sense_rd, sense_page, sense_idx} = '0;
  end
  // one byte of mode select; the stop bit always brings post error along
  task automatic wr(input logic pg, input logic [3:0] ix, input logic [7:0] v);
    sel_page = pg;
    sel_idx = ix;
    sel_data = (pg && ix == 4'h2 && v[1]) ? (v | 8'h04) : v;
    sel_wr = 1'b1;
    @(posedge ref_clk);
    #1 sel_wr = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  // start of a new mode select
  task automatic st;
    sel_start = 1'b1;
    @(posedge ref_clk);
    #1 sel_start = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  // one byte of mode sense; no valid strobe yields unknown
  task automatic rd(input logic pg, input logic [3:0] ix, output logic [7:0] v);
    sense_page = pg;
    sense_idx = ix;
    sense_rd = 1'b1;
    @(posedge ref_clk);
    #1 sense_rd = 1'b0;
    v = (sense_valid === 1'b1) ? sense_data : 8'hxx;
    @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  `define CK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end
  // clock, reset, counters
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  int   n_fail = 0;
  int   checks = 0;
  int   n;
  logic [7:0] d;
  logic [7:0] rv [12] = '{8'h81, 8'h0a, 8'hc0, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
                         8'h01, 8'h00, 8'h00, 8'h00};
  // stimulus of the core
  logic cmd_start = 1'b0, cmd_is_read = 1'b0, cmd_done = 1'b0, queue_wait = 1'b0;
  logic queue_restart = 1'b0, recov_run = 1'b0, recov_restart = 1'b0, rec_err = 1'b0;
  logic rec_err_write = 1'b0, hard_err = 1'b0, defect_found = 1'b0, defect_on_write = 1'b1;
  logic reassign_start = 1'b0, restore_fail = 1'b0, format_start = 1'b0, repurpose_done = 1'b0;
  logic [7:0] rec_step = 8'h00, temp_c = 8'h19;
  // request lines from the initiator model, and core outputs
  logic sel_start, sel_wr, sel_page, sense_rd, sense_page, sel_reject, sense_valid;
  logic [3:0] sel_idx, sense_idx;
  logic [7:0] sel_data, sense_data, read_pass_cap, write_pass_cap;
  logic cmd_abort, cmd_active, fcfs_mode, recov_timeout, skip_reassigned_lba, read_recovery_en;
  logic write_recovery_en, data_field_check_en, servo_field_check_en, report_recovered;
  logic halt_transfer, send_bad_block, check_cond, realloc_req, restore_attempt, zero_fill;
  logic fast_format_en, certify_req, temp_warn;
  erm_core #(.TICK_CYC(4)) i_erm_core (.*);
  erm_init i_erm_init (.*);
  always #25 ref_clk = ~ref_clk;
  task automatic nx;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      i_erm_init.rd(1'b1, i[3:0], d);
      `CK("recovery byte", rv[i], d)
    end
    defect_found = 1'b1;
    nx;
    defect_found = 1'b0;
    `CK("write realloc", 1'b1, realloc_req)
    i_erm_init.wr(1'b1, 4'h2, 8'h3e);
    i_erm_init.rd(1'b1, 4'h2, d);
    `CK("control byte", 8'h36, d)
    defect_on_write = 1'b0;
    defect_found = 1'b1;
    nx;
    defect_found = 1'b0;
    `CK("read realloc", 1'b0, realloc_req)
    // read threshold 16h, write threshold 00h
    for (int k = 0; k < 4; k++)
    begin
      rec_err_write = k[1];
      rec_step = k[1] ? 8'(k[0]) : 8'h16 + 8'(k[0]);
      rec_err = 1'b1;
      nx;
      rec_err = 1'b0;
      `CK("report", k[0], report_recovered)
      if (k == 1)
        `CK("halt", 1'b1, halt_transfer)
    end
    hard_err = 1'b1;
    nx;
    hard_err = 1'b0;
    `CK("bad block", 1'b1, send_bad_block)
    reassign_start = 1'b1;
    nx;
    reassign_start = 1'b0;
    `CK("restore", 1'b1, restore_attempt)
    restore_fail = 1'b1;
    nx;
    restore_fail = 1'b0;
    `CK("zero fill", 1'b1, zero_fill)
    i_erm_init.wr(1'b1, 4'h3, 8'h00);
    i_erm_init.wr(1'b1, 4'h8, 8'h00);
    `CK("read recovery", 1'b0, read_recovery_en)
    `CK("write recovery", 1'b0, write_recovery_en)
    i_erm_init.wr(1'b1, 4'h3, 8'h05);
    `CK("default cap", 8'h10, read_pass_cap)
    i_erm_init.wr(1'b0, 4'h6, 8'hc0);
    `CK("av cap", 8'h05, read_pass_cap)
    `CK("skip lba", 1'b1, skip_reassigned_lba)
    i_erm_init.wr(1'b1, 4'h2, 8'h00);
    `CK("no skip", 1'b0, skip_reassigned_lba)
    i_erm_init.wr(1'b1, 4'h1, 8'h05);
    i_erm_init.wr(1'b1, 4'h3, 8'h77);
    `CK("reject", 1'b1, sel_reject)
    i_erm_init.rd(1'b1, 4'h3, d);
    `CK("kept byte", 8'h05, d)
    i_erm_init.st;
    `CK("reject cleared", 1'b0, sel_reject)
    // command timer of two 4 cycle ticks
    i_erm_init.wr(1'b0, 4'h7, 8'h02);
    cmd_start = 1'b1;
    nx;
    cmd_start = 1'b0;
    for (n = 1; n < 40 && cmd_abort !== 1'b1; n++)
      nx;
    `CK("timeout window", 1'b1, n > 8 && n <= 16)
    nx;
    `CK("abort check", 1'b1, check_cond)
    `CK("abort ends cmd", 1'b0, cmd_active)
    cmd_done = 1'b1;
    nx;
    cmd_done = 1'b0;
    i_erm_init.wr(1'b0, 4'he, 8'h20);
    `CK("fast format", 1'b1, fast_format_en)
    for (int t = 84; t < 86; t++)
    begin
      temp_c = 8'(t);
      repeat (8) nx;
      `CK("temp warn", t == 85, temp_warn)
    end
    wrap_up;
  end
endmodule
`default_nettype wire
